// File: bis_map.svh
// Register offsets, field positions, reset values and widths of the backend
// input stage and statistics monitor.
// Assumes a 32-bit APB slave, with every register on one aligned word.
`ifndef BIS_MAP_SVH
`define BIS_MAP_SVH

// ****************************************************************************
// Register offsets (byte addresses)
// ****************************************************************************
`define BIS_ADDR_W            8
`define BIS_OFF_CTRL_FIRST    8'h00
`define BIS_OFF_CTRL_SECOND   8'h04
`define BIS_OFF_THR_BUF       8'h08
`define BIS_OFF_THR_COPY      8'h0c
`define BIS_OFF_TALLY_BUF     8'h10
`define BIS_OFF_TALLY_COPY    8'h14

// ****************************************************************************
// Field positions
// ****************************************************************************
`define BIS_CAS_SEL_BIT       0
`define BIS_SHIFT_LSB         1
`define BIS_SHIFT_MSB         5
`define BIS_RECT_LSB          6
`define BIS_RECT_MSB          7
`define BIS_MODE_LSB          0
`define BIS_MODE_MSB          1
`define BIS_FLAG_POS_BIT      22
`define BIS_FLAG_NEG_BIT      23
`define BIS_COPY_LOAD_BIT     0

// ****************************************************************************
// Widths, limits and reset values
// ****************************************************************************
`define BIS_DATA_W            22
`define BIS_CNT_W             16
`define BIS_MAX_SHIFT         4'h8
`define BIS_CTRL_RST          8'h00

`endif

// File: bis_pkg.sv
// Types shared by the backend input stage and statistics monitor.
// Assumes the constants of bis_map.svh for the field codes.
package bis_pkg;

    // ************************************************************************
    // Monitor modes, rectifier settings and register selects
    // ************************************************************************
    typedef enum logic [1:0] {
        MODE_MIN   = 2'h0,
        MODE_MAX   = 2'h1,
        MODE_UNDER = 2'h2,
        MODE_OVER  = 2'h3
    } bis_mon_mode_t;

    typedef enum logic [1:0] {
        RECT_NONE  = 2'h0,
        RECT_HALF  = 2'h1,
        RECT_FULL  = 2'h2,
        RECT_FULLB = 2'h3
    } bis_rect_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CTRL_FIRST,
        SEL_CTRL_SECOND,
        SEL_THR_BUF,
        SEL_THR_COPY,
        SEL_TALLY_BUF,
        SEL_TALLY_COPY
    } bis_reg_sel_t;

endpackage : bis_pkg

// File: bis_backend_input_stats_monitor.sv
// Backend input stage (shifter, cascade adder, rectifier) with the
// statistics monitor behind it, configured over APB.
// Assumes macData, casData and sampleValid are synchronous to ref_clk and
// that the APB master runs on ref_clk as well.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "bis_map.svh"

module bis_backend_input_stats_monitor #(
    parameter int CNT_W = `BIS_CNT_W
) (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     clkEn,

    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`BIS_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,

    input  wire logic [`BIS_DATA_W-1:0]   macData,
    input  wire logic [`BIS_DATA_W-1:0]   casData,
    input  wire logic                     sampleValid,

    output logic      [`BIS_DATA_W-1:0]   resultBus,
    output logic                          resultValid,
    output logic                          posOverflow,
    output logic                          negOverflow
);

    // ************************************************************************
    // Constants and state
    // ************************************************************************
    localparam int             DATA_W    = `BIS_DATA_W;
    localparam logic [3:0]     MAX_SHIFT = `BIS_MAX_SHIFT;
    localparam logic [DATA_W-1:0] MIN_VAL = {1'b1, {(DATA_W-1){1'b0}}};
    localparam logic [CNT_W-1:0]  CNT_TOP = {CNT_W{1'b1}};

    typedef struct packed {
        logic [7:0]        ctrlFirst;
        logic [7:0]        ctrlSecond;

        logic [DATA_W+1:0] thrBuf;
        logic [DATA_W-1:0] threshold;
        logic              ovfPos;
        logic              ovfNeg;
        logic [CNT_W-1:0]  tallyBuf;
        logic [CNT_W-1:0]  tally;

        logic [DATA_W-1:0] xData;
        logic              xValid;
        logic              xPos;
        logic              xNeg;

        logic [31:0]       rdData;
    } bis_state_t;

    // The threshold starts at the most negative value so that max mode
    // tracks from the first sample without software set-up.
    localparam bis_state_t RESET_STATE = '{
        ctrlFirst:  `BIS_CTRL_RST,
        ctrlSecond: `BIS_CTRL_RST,

        thrBuf:     '0,
        threshold:  MIN_VAL,
        ovfPos:     1'b0,
        ovfNeg:     1'b0,
        tallyBuf:   '0,
        tally:      '0,

        xData:      '0,
        xValid:     1'b0,
        xPos:       1'b0,
        xNeg:       1'b0,

        rdData:     '0
    };

    bis_state_t stateReg;
    bis_state_t stateNext;

    // ************************************************************************
    // Helper functions
    // ************************************************************************
    // Address decode, shared by the read capture and the write path.
    function automatic bis_pkg::bis_reg_sel_t decodeSel(
        input logic [`BIS_ADDR_W-1:0] addr
    );
        bis_pkg::bis_reg_sel_t sel;
        case (addr)
            `BIS_OFF_CTRL_FIRST: begin
                sel = bis_pkg::SEL_CTRL_FIRST;
            end
            `BIS_OFF_CTRL_SECOND: begin
                sel = bis_pkg::SEL_CTRL_SECOND;
            end
            `BIS_OFF_THR_BUF: begin
                sel = bis_pkg::SEL_THR_BUF;
            end
            `BIS_OFF_THR_COPY: begin
                sel = bis_pkg::SEL_THR_COPY;
            end
            `BIS_OFF_TALLY_BUF: begin
                sel = bis_pkg::SEL_TALLY_BUF;
            end
            `BIS_OFF_TALLY_COPY: begin
                sel = bis_pkg::SEL_TALLY_COPY;
            end
            default: begin
                sel = bis_pkg::SEL_NONE;
            end
        endcase
        return sel;
    endfunction : decodeSel

    // Returns {roundBit, shiftedValue}. Control bit 4 set means a right
    // shift; magnitudes above the maximum are clamped to it.
    function automatic logic [DATA_W:0] shiftRound(
        input logic [DATA_W-1:0] v,
        input logic [4:0]        ctl
    );
        logic [3:0]        amt;
        logic [DATA_W-1:0] shifted;
        logic              rnd;
        amt     = (ctl[3:0] > MAX_SHIFT) ? MAX_SHIFT : ctl[3:0];
        shifted = v;
        rnd     = 1'b0;
        if (ctl[4]) begin
            shifted = DATA_W'($signed(v) >>> amt);
            if (amt != 4'h0) begin
                // The last bit shifted out rounds the result half up.
                rnd = v[amt - 4'h1];
            end
        end else begin
            // Bits pushed out of the top are simply lost, unflagged.
            shifted = v << amt;
        end
        return {rnd, shifted};
    endfunction : shiftRound

    // Saturating increment of the event counter.
    function automatic logic [CNT_W-1:0] tallyInc(input logic [CNT_W-1:0] c);
        return (c == CNT_TOP) ? c : c + 1'b1;
    endfunction : tallyInc

    // ************************************************************************
    // Input stage: shifter, cascade adder, rectifier
    // ************************************************************************
    logic [DATA_W:0]   shiftOut;
    logic [DATA_W-1:0] casOperand;
    logic [DATA_W+1:0] cascadeSum;
    logic [DATA_W-1:0] adderOut;
    logic [DATA_W-1:0] rectOut;
    logic              sumPos;
    logic              sumNeg;

    always_comb begin
        shiftOut = shiftRound(macData,
                              stateReg.ctrlFirst[`BIS_SHIFT_MSB:`BIS_SHIFT_LSB]);
        casOperand = stateReg.ctrlFirst[`BIS_CAS_SEL_BIT] ? casData : '0;
        // Two guard bits keep the true sum, so both limits can be seen.
        cascadeSum = (DATA_W+2)'($signed(shiftOut[DATA_W-1:0]))
                   + (DATA_W+2)'($signed(casOperand))
                   + {{(DATA_W+1){1'b0}}, shiftOut[DATA_W]};
        // Above the top: sign clear with a guard bit or bit 21 set.
        sumPos = ~cascadeSum[DATA_W+1]
               & (cascadeSum[DATA_W] | cascadeSum[DATA_W-1]);
        // Below the bottom: sign set, guard bits and bit 21 not all set.
        sumNeg = cascadeSum[DATA_W+1]
               & ~(cascadeSum[DATA_W] & cascadeSum[DATA_W-1]);
        // The bus keeps the wrapped low bits; the markers carry the overflow.
        adderOut = cascadeSum[DATA_W-1:0];
        case (bis_pkg::bis_rect_t'(stateReg.ctrlFirst[`BIS_RECT_MSB:`BIS_RECT_LSB]))
            bis_pkg::RECT_NONE: begin
                rectOut = adderOut;
            end
            bis_pkg::RECT_HALF: begin
                rectOut = adderOut[DATA_W-1] ? '0 : adderOut;
            end
            bis_pkg::RECT_FULL,
            bis_pkg::RECT_FULLB: begin
                // The most negative value has no positive twin and stays put.
                if (adderOut[DATA_W-1] && adderOut != MIN_VAL) begin
                    rectOut = '0 - adderOut;
                end else begin
                    rectOut = adderOut;
                end
            end
            default: begin
                rectOut = adderOut;
            end
        endcase
    end

    // ************************************************************************
    // Next state: pipeline, monitor, APB
    // ************************************************************************
    bis_pkg::bis_reg_sel_t  setupSel;
    bis_pkg::bis_reg_sel_t  accessSel;
    bis_pkg::bis_mon_mode_t monMode;
    logic                   apbWrite;
    logic                   sampleAbove;
    logic                   sampleBelow;
    logic                   anyOverflow;
    logic                   flagClear;

    always_comb begin
        stateNext = stateReg;
        setupSel  = decodeSel(paddr);
        accessSel = setupSel;
        apbWrite  = psel & penable & pwrite & clkEn;
        flagClear = 1'b0;

        // Stage register: the result bus and its overflow markers.
        stateNext.xValid = sampleValid;
        stateNext.xPos   = sampleValid & sumPos;
        stateNext.xNeg   = sampleValid & sumNeg;
        if (sampleValid) begin
            stateNext.xData = rectOut;
        end

        // Monitor acts on the registered result, once per valid sample.
        monMode     = bis_pkg::bis_mon_mode_t'(
                          stateReg.ctrlSecond[`BIS_MODE_MSB:`BIS_MODE_LSB]);
        sampleAbove = $signed(stateReg.xData) > $signed(stateReg.threshold);
        sampleBelow = $signed(stateReg.xData) < $signed(stateReg.threshold);
        anyOverflow = stateReg.xPos | stateReg.xNeg;
        // In max and min modes the counter moves only with the threshold.
        if (stateReg.xValid) begin
            case (monMode)
                bis_pkg::MODE_MAX: begin
                    if (sampleAbove && !anyOverflow) begin
                        stateNext.threshold = stateReg.xData;
                        stateNext.tally     = tallyInc(stateReg.tally);
                    end
                end
                bis_pkg::MODE_MIN: begin
                    if (sampleBelow && !anyOverflow) begin
                        stateNext.threshold = stateReg.xData;
                        stateNext.tally     = tallyInc(stateReg.tally);
                    end
                end
                bis_pkg::MODE_OVER: begin
                    if (sampleAbove || stateReg.xPos) begin
                        stateNext.tally = tallyInc(stateReg.tally);
                    end
                end
                bis_pkg::MODE_UNDER: begin
                    if (sampleBelow) begin
                        stateNext.tally = tallyInc(stateReg.tally);
                    end
                end
                default: begin
                    stateNext.tally = stateReg.tally;
                end
            endcase
        end

        // Read data is caught in the setup cycle so prdata is a flip-flop.
        // The threshold and counter themselves never appear here.
        if (psel && !penable && !pwrite) begin
            case (setupSel)
                bis_pkg::SEL_CTRL_FIRST: begin
                    stateNext.rdData = {24'h000000, stateReg.ctrlFirst};
                end
                bis_pkg::SEL_CTRL_SECOND: begin
                    stateNext.rdData = {24'h000000, stateReg.ctrlSecond};
                end
                bis_pkg::SEL_THR_BUF: begin
                    stateNext.rdData = 32'(stateReg.thrBuf);
                end
                bis_pkg::SEL_TALLY_BUF: begin
                    stateNext.rdData = 32'(stateReg.tallyBuf);
                end
                default: begin
                    stateNext.rdData = '0;
                end
            endcase
        end

        // Software writes override a same-cycle monitor update of the threshold or counter.
        if (apbWrite) begin
            case (accessSel)
                bis_pkg::SEL_CTRL_FIRST: begin
                    stateNext.ctrlFirst = pwdata[7:0];
                end
                bis_pkg::SEL_CTRL_SECOND: begin
                    stateNext.ctrlSecond = pwdata[7:0];
                end
                bis_pkg::SEL_THR_BUF: begin
                    stateNext.thrBuf = pwdata[DATA_W+1:0];
                end
                bis_pkg::SEL_THR_COPY: begin
                    if (pwdata[`BIS_COPY_LOAD_BIT]) begin
                        stateNext.threshold = stateReg.thrBuf[DATA_W-1:0];
                    end else begin
                        // The snapshot keeps the flags as they were before clearing.
                        stateNext.thrBuf = {stateReg.ovfNeg, stateReg.ovfPos,
                                            stateReg.threshold};
                    end
                    flagClear = 1'b1;
                end
                bis_pkg::SEL_TALLY_BUF: begin
                    stateNext.tallyBuf = pwdata[CNT_W-1:0];
                end
                bis_pkg::SEL_TALLY_COPY: begin
                    if (pwdata[`BIS_COPY_LOAD_BIT]) begin
                        stateNext.tally = stateReg.tallyBuf;
                    end else begin
                        stateNext.tallyBuf = stateReg.tally;
                    end
                end
                default: begin
                    stateNext.rdData = stateReg.rdData;
                end
            endcase
        end

        // Sticky flags: an overflow in the clearing cycle survives the clear.
        stateNext.ovfPos = (stateReg.ovfPos & ~flagClear) | stateReg.xPos;
        stateNext.ovfNeg = (stateReg.ovfNeg & ~flagClear) | stateReg.xNeg;
    end

    // ************************************************************************
    // State register
    // ************************************************************************
    // Reset wins over a low clock enable, so a frozen block can be cleared.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stateReg <= RESET_STATE;
        end else if (clkEn) begin
            stateReg <= stateNext;
        end
    end

    // ************************************************************************
    // Outputs
    // ************************************************************************
    // While the clock enable is low the slave holds the master in its
    // access phase, so no write is taken by frozen state.
    assign pready      = clkEn;
    assign pslverr     = psel & penable & (accessSel == bis_pkg::SEL_NONE);
    // Data outputs come straight from the state register.
    assign prdata      = stateReg.rdData;
    assign resultBus   = stateReg.xData;
    assign resultValid = stateReg.xValid;
    assign posOverflow = stateReg.xPos;
    assign negOverflow = stateReg.xNeg;

endmodule : bis_backend_input_stats_monitor

// File: bis_checker.sv
// Port checker for the backend input stage and statistics monitor.
// Assumes it is bound to the top module and shares its single clock.
`timescale 1ns/1ps
`include "bis_map.svh"
module bis_checker (
    input wire logic                   ref_clk,
    input wire logic                   sys_rst,
    input wire logic                   clkEn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   sampleValid,
    input wire logic [`BIS_DATA_W-1:0] resultBus,
    input wire logic                   resultValid,
    input wire logic                   posOverflow,
    input wire logic                   negOverflow
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    pready_tracks_a: assert property (pready == clkEn)
        else $error("pready does not follow the clock enable");
    valid_after_sample_a: assert property (
        clkEn && sampleValid |=> resultValid) else $error("sample gave no result");
    no_spurious_valid_a: assert property (
        clkEn && !sampleValid |=> !resultValid) else $error("result without sample");
    pos_overflow_a: assert property (
        posOverflow |-> resultValid && !negOverflow) else $error("stray positive overflow");
    neg_overflow_a: assert property (
        negOverflow |-> resultValid) else $error("stray negative overflow");
    error_phase_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside an access phase");
    bus_hold_a: assert property (
        !$past(sys_rst) && $changed(resultBus) |-> resultValid && $past(clkEn))
        else $error("result bus moved without a sample");
    freeze_hold_a: assert property (
        !clkEn |=> $stable(resultBus) && $stable(resultValid) && $stable(prdata))
        else $error("state moved while the clock enable was low");
    read_hold_a: assert property (
        clkEn && !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside a read setup");
endmodule : bis_checker

// File: bis_mac_source.sv
// Model of the multiply-accumulate array and the cascade input bus.
// Assumes the bench asks for one sample per request cycle on ref_clk.
`timescale 1ns/1ps
`include "bis_map.svh"
module bis_mac_source (
    input  wire logic                   ref_clk,
    input  wire logic                   sendReq,
    input  wire logic [`BIS_DATA_W-1:0] sendMac,
    input  wire logic [`BIS_DATA_W-1:0] sendCas,
    output logic                        sampleValid,
    output logic      [`BIS_DATA_W-1:0] macData,
    output logic      [`BIS_DATA_W-1:0] casData
);
    initial begin
        sampleValid = 1'b0;
        macData     = '0;
        casData     = '0;
    end
    // Idle buses toggle so that a design sampling them out of turn is caught.
    always @(posedge ref_clk) begin
        sampleValid <= sendReq;
        macData     <= sendReq ? sendMac : ~macData;
        casData     <= sendReq ? sendCas : ~casData;
    end
endmodule : bis_mac_source

// File: bis_backend_input_stats_monitor_tb.sv
// Self-checking bench for the backend input stage and statistics monitor.
// Assumes the default counter width of 16 bits and zero-wait APB answers.
`timescale 1ns/1ps
`include "bis_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module bis_backend_input_stats_monitor_tb;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clkEn = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sendReq = 1'b0;
    logic [21:0] sendMac = 22'h0;
    logic [21:0] sendCas = 22'h0;
    logic [21:0] macData;
    logic [21:0] casData;
    logic        sampleValid;
    logic [21:0] resultBus;
    logic        resultValid;
    logic        posOverflow;
    logic        negOverflow;
    logic [31:0] rdat;
    logic        rerr;
    logic [7:0]  ctlFirst;
    int          miscompares = 0;
    int          comparisons = 0;

    always #5 ref_clk = ~ref_clk;

    bis_backend_input_stats_monitor i_bis_backend_input_stats_monitor (.ref_clk, .sys_rst,
        .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .macData, .casData, .sampleValid, .resultBus, .resultValid, .posOverflow,
        .negOverflow);
    bis_mac_source i_bis_mac_source (.ref_clk, .sendReq, .sendMac, .sendCas, .sampleValid,
        .macData, .casData);

    // ************************************************************************
    // Reference and bus tasks
    // ************************************************************************
    function automatic logic [23:0] ref_path(input logic [21:0] m, c, input logic [7:0] k);
        logic signed [23:0] v;
        logic signed [23:0] s;
        logic [21:0]        r;
        int                 n;
        n = (k[4:1] > 4'h8) ? 8 : int'(k[4:1]);
        v = {{2{m[21]}}, m};
        s = 24'sh0;
        if (k[5]) begin
            if (n > 0) s = v[n-1];
            v = v >>> n;
        end else begin
            v = v <<< n;
            v = {{2{v[21]}}, v[21:0]};
        end
        s = s + v + (k[0] ? {{2{c[21]}}, c} : 24'h0);
        r = s[21:0];
        if (k[7:6] == 2'h1 && r[21]) r = 22'h0;
        if (k[7] && r[21] && r != 22'h200000) r = -r;
        return {s < $signed(24'he00000), s > $signed(24'h1fffff), r};
    endfunction : ref_path

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (pready !== 1'b1);
        `CHK("apbWaits", 1, n)
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic setf(input logic [7:0] k);
        ctlFirst = k;
        apb(1'b1, `BIS_OFF_CTRL_FIRST, {24'h0, k});
    endtask : setf

    task automatic smp(input logic [21:0] m, c);
        logic [23:0] e;
        e = ref_path(m, c, ctlFirst);
        @(posedge ref_clk);
        sendReq <= 1'b1; sendMac <= m; sendCas <= c;
        @(posedge ref_clk);
        sendReq <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK("resultValid", 1'b1, resultValid)
        `CHK("resultBus", e[21:0], resultBus)
        `CHK("overflow", e[23:22], {negOverflow, posOverflow})
    endtask : smp

    // ************************************************************************
    // Scenarios
    // ************************************************************************
    task automatic t_reset();
        apb(1'b0, `BIS_OFF_CTRL_SECOND, 32'h0);
        `CHK("ctrlSecond", 32'h0, rdat)
        apb(1'b1, `BIS_OFF_THR_COPY, 32'h0);
        apb(1'b0, `BIS_OFF_THR_BUF, 32'h0);
        `CHK("thrReset", 32'h200000, rdat)
        apb(1'b1, `BIS_OFF_CTRL_FIRST, 32'hffffffff);
        apb(1'b0, `BIS_OFF_CTRL_FIRST, 32'h0);
        `CHK("ctrlFirst", 32'hff, rdat)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped", 33'h100000000, {rerr, rdat})
        @(posedge ref_clk);
        clkEn <= 1'b0; sendReq <= 1'b1;
        @(posedge ref_clk);
        sendReq <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK("frozen", 2'h0, {resultValid, pready})
        @(posedge ref_clk);
        clkEn <= 1'b1;
    endtask : t_reset

    task automatic t_shift();
        logic [3:0] mg;
        for (int d = 0; d < 2; d++) begin
            for (int n = 0; n < 10; n++) begin
                mg = (n == 9) ? 4'hf : n[3:0];
                setf({2'h0, d[0], mg, n[0]});
                smp(22'h0001b5, 22'h000100);
                smp(22'h3ffe4b, 22'h3fff00);
            end
        end
        for (int r = 0; r < 4; r++) begin
            setf({r[1:0], 6'h0});
            smp(22'h3ffffb, 22'h0);
            smp(22'h000005, 22'h0);
            smp(22'h200000, 22'h0);
        end
    endtask : t_shift

    task automatic t_ovf();
        setf(8'h04);
        smp(22'h100000, 22'h0);
        setf(8'h01);
        smp(22'h1fffff, 22'h000001);
        smp(22'h200000, 22'h3fffff);
        apb(1'b1, `BIS_OFF_THR_COPY, 32'h0);
        apb(1'b0, `BIS_OFF_THR_BUF, 32'h0);
        `CHK("flagsSet", 26'h0e00000, rdat[25:0])
        apb(1'b1, `BIS_OFF_THR_COPY, 32'h0);
        apb(1'b0, `BIS_OFF_THR_BUF, 32'h0);
        `CHK("flagsClear", 2'h0, rdat[23:22])
    endtask : t_ovf

    task automatic mon_run(input logic [1:0] md, input logic [21:0] thr, a, b, c, om, oc,
                           input logic [15:0] cnt0, input logic [21:0] eThr,
                           input logic [15:0] eCnt);
        apb(1'b1, `BIS_OFF_THR_BUF, {10'h0, thr});
        apb(1'b1, `BIS_OFF_THR_COPY, 32'h1);
        apb(1'b1, `BIS_OFF_TALLY_BUF, {16'h0, cnt0});
        apb(1'b1, `BIS_OFF_TALLY_COPY, 32'h1);
        apb(1'b1, `BIS_OFF_CTRL_SECOND, {30'h0, md});
        smp(a, 22'h0);
        smp(b, 22'h0);
        smp(c, 22'h0);
        smp(om, oc);
        apb(1'b1, `BIS_OFF_THR_COPY, 32'h0);
        apb(1'b0, `BIS_OFF_THR_BUF, 32'h0);
        `CHK("threshold", eThr, rdat[21:0])
        apb(1'b1, `BIS_OFF_TALLY_COPY, 32'h0);
        apb(1'b0, `BIS_OFF_TALLY_BUF, 32'h0);
        `CHK("tally", eCnt, rdat[15:0])
    endtask : mon_run

    task automatic final_report();
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_shift();
        t_ovf();
        mon_run(2'h1, 22'h0, 22'h5, 22'h3, 22'h9, 22'h200000, 22'h3fffff, 16'h0, 22'h9,
                16'h2);
        mon_run(2'h0, 22'h64, 22'h32, 22'h46, 22'h14, 22'h0, 22'h0, 16'h0, 22'h0,
                16'h3);
        mon_run(2'h3, 22'ha, 22'hb, 22'ha, 22'hc, 22'h1fffff, 22'h1, 16'h0, 22'ha,
                16'h3);
        mon_run(2'h3, 22'ha, 22'hb, 22'ha, 22'hc, 22'h1fffff, 22'h1, 16'hfffe, 22'ha,
                16'hffff);
        mon_run(2'h2, 22'ha, 22'h9, 22'ha, 22'h3fffff, 22'h0, 22'h0, 16'h0, 22'ha,
                16'h3);
        final_report();
    end

    // The whole run needs under five hundred cycles; the limit leaves wide margin.
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end
endmodule : bis_backend_input_stats_monitor_tb

bind bis_backend_input_stats_monitor bis_checker i_bis_checker (.ref_clk, .sys_rst, .clkEn,
    .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .sampleValid, .resultBus,
    .resultValid, .posOverflow, .negOverflow);
